//--- verilog/flpi_map.svh
// Register offsets, field positions, reset values and vector addresses of the interrupt priority block
`ifndef FLPI_MAP_SVH
`define FLPI_MAP_SVH

`define FLPI_ADDR_ENABLE_MASK    8'ha8
`define FLPI_ADDR_PRIORITY_LOW   8'hb8
`define FLPI_ADDR_PRIORITY_HIGH  8'hb7

`define FLPI_RESET_ENABLE_MASK   8'h00
`define FLPI_RESET_PRIORITY_LOW  7'h00
`define FLPI_RESET_PRIORITY_HIGH 7'h00

`define FLPI_GLOBAL_ENABLE_BIT   7

`define FLPI_BIT_EXT_ZERO        3'h0
`define FLPI_BIT_TIMER_ZERO      3'h1
`define FLPI_BIT_EXT_ONE         3'h2
`define FLPI_BIT_TIMER_ONE       3'h3
`define FLPI_BIT_SERIAL          3'h4
`define FLPI_BIT_TIMER_TWO       3'h5
`define FLPI_BIT_COUNTER_ARRAY   3'h6

// Register bit index per polling position, position 0 in the low three bits
`define FLPI_POLL_ORDER {3'h5, 3'h4, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0}

`define FLPI_VEC_EXT_ZERO        8'h03
`define FLPI_VEC_TIMER_ZERO      8'h0b
`define FLPI_VEC_EXT_ONE         8'h13
`define FLPI_VEC_TIMER_ONE       8'h1b
`define FLPI_VEC_SERIAL          8'h23
`define FLPI_VEC_TIMER_TWO       8'h2b
`define FLPI_VEC_COUNTER_ARRAY   8'h33

`endif

//--- verilog/flpi_pkg.sv
// Types shared by the interrupt priority block
package flpi_pkg;

    typedef logic [1:0] flpi_level_t;

    typedef struct packed {
        logic [7:0]  enableMask;
        logic [6:0]  priLow;
        logic [6:0]  priHigh;
        logic [3:0]  inService;
        logic        irqReq;
        logic [7:0]  vector;
        logic [2:0]  curIdx;
        flpi_level_t curLevel;
        logic [6:0]  hwClear;
        logic [7:0]  rdata;
    } flpi_state_t;

endpackage

//--- verilog/flpi_arbiter.sv
// Picks the highest level pending request, polling order breaking ties
`timescale 1ns/1ps
`include "flpi_map.svh"

module flpi_arbiter #(
    parameter int NUM_SRC = 7
) (
    input  wire logic [NUM_SRC-1:0] request,
    input  wire logic [NUM_SRC-1:0] priLow,
    input  wire logic [NUM_SRC-1:0] priHigh,
    output logic                    found,
    output logic [2:0]              winIdx,
    output flpi_pkg::flpi_level_t   winLevel
);

    localparam logic [3*NUM_SRC-1:0] POLL_ORDER = `FLPI_POLL_ORDER;

    logic [2:0] idx;

    always_comb begin
        found    = 1'b0;
        winIdx   = 3'h0;
        winLevel = 2'h0;
        idx      = 3'h0;
        for (int lv = 3; lv >= 0; lv--) begin
            for (int k = 0; k < NUM_SRC; k++) begin
                idx = POLL_ORDER[k*3 +: 3];
                if (!found && request[idx] && {priHigh[idx], priLow[idx]} == 2'(lv)) begin
                    found    = 1'b1;
                    winIdx   = idx;
                    winLevel = 2'(lv);
                end
            end
        end
    end

endmodule // flpi_arbiter

//--- verilog/flpi_controller.sv
// Four-level nested interrupt priority controller with its three special-function registers
`timescale 1ns/1ps
`include "flpi_map.svh"

module flpi_controller #(
    parameter int NUM_SRC = 7
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  clkEn,
    input  wire logic [7:0]            sfrAddr,
    input  wire logic                  sfrWrite,
    input  wire logic                  sfrRead,
    input  wire logic [7:0]            sfrWdata,
    output logic [7:0]                 sfrRdata,
    input  wire logic [NUM_SRC-1:0]    srcFlag,
    input  wire logic [1:0]            extEdgeMode,
    output logic                       irqRequest,
    output logic [7:0]                 irqVector,
    output flpi_pkg::flpi_level_t      irqLevel,
    input  wire logic                  cpuAck,
    input  wire logic                  cpuReturn,
    output logic [NUM_SRC-1:0]         hwClear,
    output logic [3:0]                 inServiceLevels
);

    ////////////////////////////////////////////////////////////////////////////
    // State and per-source gating

    flpi_pkg::flpi_state_t st;
    flpi_pkg::flpi_state_t next_st;

    logic [NUM_SRC-1:0]    gatedReq;
    logic                  found;
    logic [2:0]            winIdx;
    flpi_pkg::flpi_level_t winLevel;
    flpi_pkg::flpi_level_t topLevel;
    logic                  eligible;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gen_gate
            assign gatedReq[g] = srcFlag[g] & st.enableMask[g]
                               & st.enableMask[`FLPI_GLOBAL_ENABLE_BIT];
        end
    endgenerate

    flpi_arbiter #(
        .NUM_SRC (NUM_SRC)
    ) u_arbiter (
        .request  (gatedReq),
        .priLow   (st.priLow),
        .priHigh  (st.priHigh),
        .found    (found),
        .winIdx   (winIdx),
        .winLevel (winLevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Level stack helpers

    always_comb begin
        topLevel = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (st.inService[i]) begin
                topLevel = 2'(i);
            end
        end
    end

    // Only strictly higher than the top in-service level may be taken
    assign eligible = found && (st.inService == 4'h0 || winLevel > topLevel);

    ////////////////////////////////////////////////////////////////////////////
    // Register selects and level stack events

    logic       selEnable;
    logic       selPriLow;
    logic       selPriHigh;
    logic       wrEnable;
    logic       wrPriLow;
    logic       wrPriHigh;
    logic       ackTaken;
    logic [3:0] topMask;
    logic [3:0] pushMask;
    logic [3:0] popMask;

    assign selEnable  = (sfrAddr == `FLPI_ADDR_ENABLE_MASK);
    assign selPriLow  = (sfrAddr == `FLPI_ADDR_PRIORITY_LOW);
    assign selPriHigh = (sfrAddr == `FLPI_ADDR_PRIORITY_HIGH);
    assign wrEnable   = sfrWrite & selEnable;
    assign wrPriLow   = sfrWrite & selPriLow;
    assign wrPriHigh  = sfrWrite & selPriHigh;

    // An ack only counts while a vector is on offer
    assign ackTaken = st.irqReq & cpuAck;

    // Push and pop never meet on one bit: an accepted level is always above the old top
    genvar lv;
    generate
        for (lv = 0; lv < 4; lv++) begin : gen_level
            assign topMask[lv]  = st.inService[lv] & ((st.inService >> (lv + 1)) == 4'h0);
            assign pushMask[lv] = ackTaken & (st.curLevel == 2'(lv));
            assign popMask[lv]  = cpuReturn & topMask[lv];
        end
    endgenerate

    function automatic logic [7:0] vectorOf(input logic [2:0] idx);
        unique case (idx)
            `FLPI_BIT_EXT_ZERO:      vectorOf = `FLPI_VEC_EXT_ZERO;
            `FLPI_BIT_TIMER_ZERO:    vectorOf = `FLPI_VEC_TIMER_ZERO;
            `FLPI_BIT_EXT_ONE:       vectorOf = `FLPI_VEC_EXT_ONE;
            `FLPI_BIT_TIMER_ONE:     vectorOf = `FLPI_VEC_TIMER_ONE;
            `FLPI_BIT_SERIAL:        vectorOf = `FLPI_VEC_SERIAL;
            `FLPI_BIT_TIMER_TWO:     vectorOf = `FLPI_VEC_TIMER_TWO;
            `FLPI_BIT_COUNTER_ARRAY: vectorOf = `FLPI_VEC_COUNTER_ARRAY;
            default:                 vectorOf = 8'h00;
        endcase
    endfunction

    function automatic logic hwClearable(input logic [2:0] idx, input logic [1:0] edgeMode);
        unique case (idx)
            `FLPI_BIT_TIMER_ZERO, `FLPI_BIT_TIMER_ONE: hwClearable = 1'b1;
            `FLPI_BIT_EXT_ZERO:                        hwClearable = edgeMode[0];
            `FLPI_BIT_EXT_ONE:                         hwClearable = edgeMode[1];
            default:                                   hwClearable = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st         = st;
        next_st.hwClear = '0;

        // Register writes
        if (wrEnable) begin
            next_st.enableMask = sfrWdata;
        end
        if (wrPriLow) begin
            next_st.priLow = sfrWdata[6:0];
        end
        if (wrPriHigh) begin
            next_st.priHigh = sfrWdata[6:0];
        end

        // Register reads, unused bit and unmapped addresses read zero
        if (sfrRead) begin
            if (selEnable) begin
                next_st.rdata = st.enableMask;
            end else if (selPriLow) begin
                next_st.rdata = {1'b0, st.priLow};
            end else if (selPriHigh) begin
                next_st.rdata = {1'b0, st.priHigh};
            end else begin
                next_st.rdata = 8'h00;
            end
        end

        // Core takes the vector: pulse the hardware clear of a timer 0/1 or edge-mode external source, stop offering
        if (ackTaken) begin
            if (hwClearable(st.curIdx, extEdgeMode)) begin
                next_st.hwClear[st.curIdx] = 1'b1;
            end
            next_st.irqReq = 1'b0;
        end else begin
            next_st.irqReq   = eligible;
            next_st.curIdx   = winIdx;
            next_st.curLevel = winLevel;
            next_st.vector   = vectorOf(winIdx);
        end

        // Ack pushes its level, return pops the top one; lower levels resume
        if (ackTaken || cpuReturn) begin
            next_st.inService = (st.inService | pushMask) & ~popMask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // Registers to their reset values, the offer and stack cleared
            st.enableMask <= `FLPI_RESET_ENABLE_MASK;
            st.priLow     <= `FLPI_RESET_PRIORITY_LOW;
            st.priHigh    <= `FLPI_RESET_PRIORITY_HIGH;
            st.inService  <= 4'h0;
            st.irqReq     <= 1'b0;
            st.vector     <= 8'h00;
            st.curIdx     <= 3'h0;
            st.curLevel   <= 2'h0;
            st.hwClear    <= 7'h00;
            st.rdata      <= 8'h00;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign sfrRdata        = st.rdata;
    assign irqRequest      = st.irqReq;
    assign irqVector       = st.vector;
    assign irqLevel        = st.curLevel;
    assign hwClear         = st.hwClear;
    assign inServiceLevels = st.inService;

endmodule // flpi_controller

//--- testbench/flpi_cpu_model.sv
// Core model: acks an offered vector after a set wait, returns on command
`timescale 1ns/1ps

module flpi_cpu_model (
    input  wire logic       sys_clk,
    input  wire logic       irqRequest,
    input  wire logic [1:0] ackWait,
    input  wire logic       retCmd,
    output logic            cpuAck,
    output logic            cpuReturn
);
    logic [1:0] w = 2'h0;
    logic [1:0] aw;
    logic       r;

    initial {cpuAck, cpuReturn} = 2'h0;
    always @(posedge sys_clk) begin
        {r, aw} = {retCmd, ackWait};
        #1 cpuReturn = r;
        if (cpuAck || !irqRequest) {cpuAck, w} = 3'h0;
        else if (w == aw) cpuAck = 1'b1;
        else w = w + 2'h1;
    end
endmodule // flpi_cpu_model

//--- testbench/flpi_controller_sva.sv
// Port checks of the interrupt priority controller
`timescale 1ns/1ps

module flpi_controller_sva #(
    parameter int NUM_SRC = 7
) (
    input wire logic                  sys_clk,
    input wire logic                  resetn,
    input wire logic                  clkEn,
    input wire logic                  irqRequest,
    input wire logic [7:0]            irqVector,
    input wire flpi_pkg::flpi_level_t irqLevel,
    input wire logic                  cpuAck,
    input wire logic                  cpuReturn,
    input wire logic [NUM_SRC-1:0]    hwClear,
    input wire logic [3:0]            inServiceLevels
);
    logic take;
    assign take = irqRequest && cpuAck && clkEn;
    function automatic logic [3:0] pop(input logic [3:0] s);
        return s[3] ? s & 4'h7 : s[2] ? s & 4'h3 : s[1] ? s & 4'h1 : 4'h0;
    endfunction
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_ack_drops_req: assert property (take |=> !irqRequest) else $error("request held after ack");
    chk_ack_pushes_lvl: assert property (take && !cpuReturn |=>
        inServiceLevels == ($past(inServiceLevels) | (4'h1 << $past(irqLevel)))) else $error("level not pushed");
    chk_req_above_all: assert property (irqRequest |-> (inServiceLevels >> irqLevel) == 4'h0)
        else $error("request not above in-service level");
    chk_vector_legal: assert property (irqRequest |->
        irqVector inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33}) else $error("bad vector");
    chk_ret_pops_top: assert property (cpuReturn && clkEn && !take |=>
        inServiceLevels == pop($past(inServiceLevels))) else $error("return did not pop top level");
    chk_clr_one_cycle: assert property (hwClear != '0 |=> hwClear == '0) else $error("clear too long");
    chk_clr_after_ack: assert property (hwClear != '0 |-> $past(take)) else $error("clear without ack");
    chk_clr_kinds: assert property ($onehot0(hwClear) && hwClear[6:4] == 3'h0) else $error("bad clear");
endmodule // flpi_controller_sva

bind flpi_controller flpi_controller_sva #(.NUM_SRC(NUM_SRC)) uSva (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .clkEn           (clkEn),
    .irqRequest      (irqRequest),
    .irqVector       (irqVector),
    .irqLevel        (irqLevel),
    .cpuAck          (cpuAck),
    .cpuReturn       (cpuReturn),
    .hwClear         (hwClear),
    .inServiceLevels (inServiceLevels)
);

//--- testbench/tb.sv
// Self-checking bench of the interrupt priority controller
`timescale 1ns/1ps

module tb;
    logic                  sys_clk = 1'b0, resetn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, rdPend = 1'b0;
    logic                  retCmd = 1'b0, clkEn = 1'b1, irqRequest, cpuAck, cpuReturn;
    logic [7:0]            sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, irqVector, d, rq[$];
    logic [6:0]            srcFlag = 7'h00, hwClear;
    logic [1:0]            extEdgeMode = 2'h0, ackWait = 2'h0;
    logic [3:0]            inServiceLevels;
    logic [9:0]            vq[$];
    flpi_pkg::flpi_level_t irqLevel;
    int                    errors = 0, compares = 0, cyc = 0;
    logic [2:0]            ob[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5};
    logic [7:0]            ov[7] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h33, 8'h23, 8'h2b};
    logic [7:0]            ad[3] = '{8'ha8, 8'hb8, 8'hb7};

    always #10 sys_clk = ~sys_clk;
    flpi_controller #(.NUM_SRC(7)) DUT (
        .sys_clk         (sys_clk),
        .resetn          (resetn),
        .clkEn           (clkEn),
        .sfrAddr         (sfrAddr),
        .sfrWrite        (sfrWrite),
        .sfrRead         (sfrRead),
        .sfrWdata        (sfrWdata),
        .sfrRdata        (sfrRdata),
        .srcFlag         (srcFlag),
        .extEdgeMode     (extEdgeMode),
        .irqRequest      (irqRequest),
        .irqVector       (irqVector),
        .irqLevel        (irqLevel),
        .cpuAck          (cpuAck),
        .cpuReturn       (cpuReturn),
        .hwClear         (hwClear),
        .inServiceLevels (inServiceLevels)
    );
    flpi_cpu_model core (
        .sys_clk    (sys_clk),
        .irqRequest (irqRequest),
        .ackWait    (ackWait),
        .retCmd     (retCmd),
        .cpuAck     (cpuAck),
        .cpuReturn  (cpuReturn)
    );
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [9:0] g, e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        {sfrAddr, sfrWdata, sfrWrite} = {a, v, 1'b1};
        @(posedge sys_clk);
        #1 sfrWrite = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, v);
        {sfrAddr, sfrRead} = {a, 1'b1};
        rq.push_back(v);
        @(posedge sys_clk);
        #1 sfrRead = 1'b0;
        step(1);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic quiet();
        step(6);
        chk({9'h0, irqRequest}, 10'h0);
    endtask
    // Waits for the ack of source b, then drops its flag as the handler would
    task automatic take(input logic [2:0] b);
        int n = 0;
        logic [6:0] h = 7'h0;
        h[b] = b == 3'h1 || b == 3'h3 || (b == 3'h0 || b == 3'h2) && extEdgeMode[b[1]];
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(irqRequest === 1'b1 && cpuAck === 1'b1) && n < 40);
        #1 srcFlag[b] = 1'b0;
        chk({3'h0, hwClear}, {3'h0, h});
    endtask
    task automatic ret();
        retCmd = 1'b1;
        step(1);
        retCmd = 1'b0;
        step(2);
    endtask
    task automatic wrap_up();
        if (errors == 0 && compares > 0 && vq.size() == 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (rdPend) chk({2'h0, sfrRdata}, {2'h0, rq.pop_front()});
        if (irqRequest === 1'b1 && cpuAck === 1'b1) chk({irqLevel, irqVector}, vq.pop_front());
        rdPend <= sfrRead;
        cyc++;
        if (cyc == 4000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h689185f8));
        extEdgeMode = 2'($urandom);
        step(10);
        resetn = 1'b1;
        d = 8'($urandom);
        for (int i = 0; i < 3; i++) begin
            rd(ad[i], 8'h00);
            wr(ad[i], d);
            rd(ad[i], (i == 0) ? d : d & 8'h7f);
        end
        wr(8'ha9, 8'hff);
        rd(8'ha9, 8'h00);
        wr(8'ha8, 8'hff);
        for (int lv = 0; lv < 4; lv++) begin
            ackWait = 2'($urandom);
            wr(8'hb8, {8{lv[0]}});
            wr(8'hb7, {8{lv[1]}});
            for (int i = 0; i < 7; i++) vq.push_back({2'(lv), ov[i]});
            srcFlag = 7'h7f;
            for (int i = 0; i < 7; i++) begin
                take(ob[i]);
                ret();
            end
        end
        // Serial at level 1, timer 2 at level 3, external 0 at level 2
        wr(8'hb8, 8'h30);
        wr(8'hb7, 8'h21);
        wr(8'ha8, 8'hb1);
        vq = '{{2'h1, 8'h23}, {2'h3, 8'h2b}, {2'h2, 8'h03}};
        srcFlag[4] = 1'b1;
        take(3'h4);
        step(1);
        srcFlag[5] = 1'b1;
        take(3'h5);
        chk({6'h0, inServiceLevels}, 10'h00a);
        step(1);
        srcFlag[0] = 1'b1;
        quiet();
        ret();
        take(3'h0);
        chk({6'h0, inServiceLevels}, 10'h006);
        ret();
        ret();
        chk({6'h0, inServiceLevels}, 10'h000);
        wr(8'ha8, 8'h7f);
        srcFlag = 7'h7f;
        quiet();
        wr(8'ha8, 8'h80);
        quiet();
        // Writes are ignored while the clock enable is low
        clkEn = 1'b0;
        wr(8'hb8, 8'h55);
        clkEn = 1'b1;
        rd(8'hb8, 8'h30);
        step(2);
        wrap_up();
    end
endmodule // tb
